/* File: hw/plc_phy_end.sv */
// phy end of the phy/link control interface: owns the control pair and data
// bus, queues bus requests, serves register requests, grants the interface.
// assumes the link end keeps its own signalling; one 40 mhz clock for all.
`timescale 1ns/1ps
// Summary of operation
// - phy drives buses; link only after grant
// - status transfer autonomous or for register read
// - receive operation for each arriving packet
// - won arbitration starts transmit with grant
// - phy codes idle, status, receive, grant
// - link codes release, transmit; 10 reserved
// - link 11 holds, requests, marks gap end
// - link shifts requests one bit per clock
// - bus request stream is 11 bits
// - read 10, write 18, notify 6 bits
// - start bit 1, stop bit 0
// - four type bits follow start, msb first
// - request line low when idle
// - async bus request types pick arbitration mode
// - iso and cycle start arbitration types
// - register read returns status, write stores
// - notifications set iso phase, cycle start due
// - phy clocks all outputs on rising edge
// - link transfers synchronous to returned clock; here no clock is returned, both ends share one clock
// - bus request format, speed, stop fields
module plc_phy_end (
	input wire logic clock,
	input wire logic rst,
	plc_if.phy pins,
	input wire logic pkt_arrive,
	input wire logic [7:0] pkt_byte,
	input wire logic pkt_last,
	input wire logic arb_won,
	input wire logic status_req,
	input wire logic [7:0] status_byte,
	output logic [15:0] arb_pending,
	output logic [3:0] arb_type,
	output logic arb_format,
	output logic [3:0] arb_speed,
	output logic iso_phase_odd,
	output logic cyc_start_due,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	output logic [plc_pkg::NUM_REGS*8-1:0] reg_view
);
	import plc_pkg::*;

	typedef enum logic [3:0] {
		PLC_IDLE = 4'h1,
		PLC_STATUS = 4'h2,
		PLC_RECEIVE = 4'h4,
		PLC_GRANT = 4'h8
	} plc_state_e;

	logic rx_done;
	logic [3:0] rx_type;
	logic [12:0] rx_pay;

	// serial request collector on the request line
	plc_req_rx u_rx (
		.clock(clock),
		.rst(rst),
		.req_bit(pins.link_request_line),
		.done(rx_done),
		.rtype(rx_type),
		.payload(rx_pay)
	);

	plc_state_e st_ff, nxt_st;
	logic [15:0] pend_ff, nxt_pend;
	logic [4:0] fld_ff [NUM_TYPES];
	logic [4:0] nxt_fld [NUM_TYPES];
	logic [3:0] arb_ff, nxt_arb;
	logic [7:0] regs_ff [NUM_REGS];
	logic [7:0] nxt_regs [NUM_REGS];
	logic rd_pend_ff, nxt_rd_pend;
	logic [3:0] rd_addr_ff, nxt_rd_addr;
	logic iso_odd_ff, nxt_iso_odd;
	logic due_ff, nxt_due;
	logic [1:0] ctl_ff, nxt_ctl;
	logic ctl_oe_ff, nxt_ctl_oe;
	logic [7:0] dat_ff, nxt_dat;
	logic dat_oe_ff, nxt_dat_oe;
	logic [7:0] txb_ff, nxt_txb;
	logic txv_ff, nxt_txv;

	// lowest pending bus request type gets the arbitration slot
	function automatic logic [3:0] plc_pick(input logic [15:0] p);
		plc_pick = 4'h0;
		for (int i = NUM_TYPES - 1; i > 0; i--) begin
			if (p[i]) begin
				plc_pick = 4'(i);
			end
		end
	endfunction : plc_pick

	// request decode, queue, register file and interface sequencing
	always_comb begin
		nxt_st = st_ff;
		nxt_pend = pend_ff;
		nxt_fld = fld_ff;
		nxt_arb = arb_ff;
		nxt_regs = regs_ff;
		nxt_rd_pend = rd_pend_ff;
		nxt_rd_addr = rd_addr_ff;
		nxt_iso_odd = iso_odd_ff;
		nxt_due = due_ff;
		nxt_ctl = PHY_CTL_IDLE;
		nxt_ctl_oe = 1'b1;
		nxt_dat = 8'h00;
		nxt_dat_oe = 1'b1;
		nxt_txb = txb_ff;
		nxt_txv = 1'b0;
		if (rx_done) begin
			case (plc_len(rx_type))
				LEN_BUS: begin
					// one queued request per type, newer overwrites
					nxt_pend[rx_type] = 1'b1;
					nxt_fld[rx_type] = rx_pay[4:0];
				end
				LEN_READ: begin
					if (!rd_pend_ff) begin // repeat reads ignored while one waits
						nxt_rd_pend = 1'b1;
						nxt_rd_addr = rx_pay[3:0];
					end
				end
				LEN_WRITE: begin
					nxt_regs[rx_pay[11:8]] = rx_pay[7:0];
				end
				LEN_NOTIFY: begin
					if (rx_type == RT_CYC_DUE) begin
						nxt_due = 1'b1;
					end else begin
						nxt_iso_odd = (rx_type == RT_PHASE_ODD);
						nxt_due = 1'b0;
					end
				end
				default: begin
					nxt_due = due_ff; // reserved types never reach here
				end
			endcase
		end
		case (st_ff)
			PLC_IDLE: begin
				if (pkt_arrive) begin
					nxt_st = PLC_RECEIVE;
					nxt_ctl = PHY_CTL_RECEIVE;
					nxt_dat = pkt_byte;
				end else if (arb_won && pend_ff != 16'h0000) begin
					nxt_st = PLC_GRANT;
					nxt_ctl = PHY_CTL_GRANT;
					nxt_arb = plc_pick(pend_ff);
					// cleared only on a win; a fresh request of that type in this cycle stays
					if (!(rx_done && plc_len(rx_type) == LEN_BUS && rx_type == plc_pick(pend_ff))) begin
						nxt_pend[plc_pick(pend_ff)] = 1'b0;
					end
				end else if (rd_pend_ff || status_req) begin
					nxt_st = PLC_STATUS;
					nxt_ctl = PHY_CTL_STATUS;
					nxt_dat = rd_pend_ff ? regs_ff[rd_addr_ff] : status_byte;
					nxt_rd_pend = 1'b0;
				end
			end
			PLC_STATUS: begin
				nxt_st = PLC_IDLE; // one status byte, then back to idle
			end
			PLC_RECEIVE: begin
				nxt_ctl = PHY_CTL_RECEIVE;
				nxt_dat = pkt_byte;
				if (pkt_last) begin
					nxt_st = PLC_IDLE;
					nxt_ctl = PHY_CTL_IDLE;
					nxt_dat = 8'h00;
				end
			end
			PLC_GRANT: begin
				// the link owns both buses until it releases
				nxt_ctl_oe = 1'b0;
				nxt_dat_oe = 1'b0;
				if (ctl_oe_ff) begin
					nxt_ctl_oe = 1'b0; // grant cycle done, hand over
				end else if (pins.iface_control_pair == LNK_CTL_TRANSMIT) begin
					nxt_txb = pins.iface_data_byte_bus;
					nxt_txv = 1'b1;
				end else if (pins.iface_control_pair == LNK_CTL_RELEASE) begin
					nxt_st = PLC_IDLE;
					nxt_ctl_oe = 1'b1;
					nxt_dat_oe = 1'b1;
				end
				// hold code keeps the grant, reserved code does nothing
			end
			default: begin
				nxt_st = PLC_IDLE;
			end
		endcase
		// a read taken in the same cycle as an autonomous status still stands
		if (rx_done && plc_len(rx_type) == LEN_READ && !rd_pend_ff) begin
			nxt_rd_pend = 1'b1;
		end
	end

	// register all phy state on the rising edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= PLC_IDLE;
			pend_ff <= 16'h0000;
			for (int i = 0; i < NUM_TYPES; i++) begin
				fld_ff[i] <= 5'h00;
			end
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_ff[i] <= REG_RESET_VAL;
			end
			arb_ff <= 4'h0;
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= 4'h0;
			iso_odd_ff <= 1'b0;
			due_ff <= 1'b0;
			ctl_ff <= PHY_CTL_IDLE;
			ctl_oe_ff <= 1'b1;
			dat_ff <= 8'h00;
			dat_oe_ff <= 1'b1;
			txb_ff <= 8'h00;
			txv_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			pend_ff <= nxt_pend;
			fld_ff <= nxt_fld;
			regs_ff <= nxt_regs;
			arb_ff <= nxt_arb;
			rd_pend_ff <= nxt_rd_pend;
			rd_addr_ff <= nxt_rd_addr;
			iso_odd_ff <= nxt_iso_odd;
			due_ff <= nxt_due;
			ctl_ff <= nxt_ctl;
			ctl_oe_ff <= nxt_ctl_oe;
			dat_ff <= nxt_dat;
			dat_oe_ff <= nxt_dat_oe;
			txb_ff <= nxt_txb;
			txv_ff <= nxt_txv;
		end
	end

	// pin and user outputs, all from flops
	assign pins.phy_ctl_o = ctl_ff;
	assign pins.phy_ctl_oe = ctl_oe_ff;
	assign pins.phy_data_o = dat_ff;
	assign pins.phy_data_oe = dat_oe_ff;
	assign arb_pending = pend_ff;
	assign arb_type = arb_ff;
	assign arb_format = fld_ff[arb_ff][4];
	assign arb_speed = fld_ff[arb_ff][3:0];
	assign iso_phase_odd = iso_odd_ff;
	assign cyc_start_due = due_ff;
	assign tx_byte = txb_ff;
	assign tx_valid = txv_ff;
	for (genvar g = 0; g < NUM_REGS; g++) begin : g_view
		assign reg_view[g*8 +: 8] = regs_ff[g];
	end
endmodule : plc_phy_end

/* File: hw/plc_pkg.sv */
// shared definitions for the phy/link control interface: control codes,
// request types, stream lengths, start and stop bit values and table sizes.
// assumes both ends are compiled against this package.
package plc_pkg;
	// control pair codes while the phy drives
	localparam logic [1:0] PHY_CTL_IDLE = 2'h0;
	localparam logic [1:0] PHY_CTL_STATUS = 2'h1;
	localparam logic [1:0] PHY_CTL_RECEIVE = 2'h2;
	localparam logic [1:0] PHY_CTL_GRANT = 2'h3;
	// control pair codes while the link drives
	localparam logic [1:0] LNK_CTL_RELEASE = 2'h0;
	localparam logic [1:0] LNK_CTL_TRANSMIT = 2'h1;
	localparam logic [1:0] LNK_CTL_RESERVED = 2'h2;
	localparam logic [1:0] LNK_CTL_HOLD = 2'h3;
	// request type codes
	localparam logic [3:0] RT_IMMED = 4'h1;
	localparam logic [3:0] RT_NEXT_EVEN = 4'h2;
	localparam logic [3:0] RT_NEXT_ODD = 4'h3;
	localparam logic [3:0] RT_CURRENT = 4'h4;
	localparam logic [3:0] RT_ISO_EVEN = 4'h6;
	localparam logic [3:0] RT_ISO_ODD = 4'h7;
	localparam logic [3:0] RT_CYC_START = 4'h8;
	localparam logic [3:0] RT_REG_READ = 4'ha;
	localparam logic [3:0] RT_REG_WRITE = 4'hb;
	localparam logic [3:0] RT_PHASE_EVEN = 4'hc;
	localparam logic [3:0] RT_PHASE_ODD = 4'hd;
	localparam logic [3:0] RT_CYC_DUE = 4'he;
	// stream lengths in bits, start and stop included
	localparam logic [4:0] LEN_BUS = 5'h0b;
	localparam logic [4:0] LEN_READ = 5'h0a;
	localparam logic [4:0] LEN_WRITE = 5'h12;
	localparam logic [4:0] LEN_NOTIFY = 5'h06;
	localparam logic [4:0] LEN_MAX = 5'h12;
	localparam int TYPE_BITS = 4;
	localparam logic START_BIT = 1'b1;
	localparam logic STOP_BIT = 1'b0;
	// request classes seen by the phy core
	typedef enum logic [2:0] {
		PLC_CLS_BUS = 3'h1,
		PLC_CLS_REG = 3'h2,
		PLC_CLS_NOTE = 3'h4
	} plc_class_e;
	// queue slots indexed by type code, register count and register reset value
	localparam int NUM_TYPES = 16;
	localparam int NUM_REGS = 16;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// stream length for a given type; zero marks a discarded type
	function automatic logic [4:0] plc_len(input logic [3:0] t);
		case (t)
			RT_IMMED, RT_NEXT_EVEN, RT_NEXT_ODD, RT_CURRENT,
			RT_ISO_EVEN, RT_ISO_ODD, RT_CYC_START: plc_len = LEN_BUS;
			RT_REG_READ: plc_len = LEN_READ;
			RT_REG_WRITE: plc_len = LEN_WRITE;
			RT_PHASE_EVEN, RT_PHASE_ODD, RT_CYC_DUE: plc_len = LEN_NOTIFY;
			default: plc_len = 5'h00;
		endcase
	endfunction : plc_len
endpackage : plc_pkg

/* File: hw/plc_if.sv */
// pin-level interface between the phy end and the link end.
// resolves the shared control and data wires here from the enables, phy end first.
`timescale 1ns/1ps
interface plc_if;
	logic [1:0] phy_ctl_o;
	logic phy_ctl_oe;
	logic [7:0] phy_data_o;
	logic phy_data_oe;
	logic [1:0] lnk_ctl_o;
	logic lnk_ctl_oe;
	logic [7:0] lnk_data_o;
	logic lnk_data_oe;
	logic [1:0] iface_control_pair;
	logic [7:0] iface_data_byte_bus;
	logic link_request_line;
	// resolved wire levels
	assign iface_control_pair = phy_ctl_oe ? phy_ctl_o : (lnk_ctl_oe ? lnk_ctl_o : 2'h0);
	assign iface_data_byte_bus = phy_data_oe ? phy_data_o : (lnk_data_oe ? lnk_data_o : 8'h00);
	modport phy (
		output phy_ctl_o, phy_ctl_oe, phy_data_o, phy_data_oe,
		input iface_control_pair, iface_data_byte_bus, link_request_line
	);
	modport link (
		output lnk_ctl_o, lnk_ctl_oe, lnk_data_o, lnk_data_oe, link_request_line,
		input iface_control_pair, iface_data_byte_bus
	);
endinterface : plc_if

/* File: hw/plc_req_rx.sv */
// serial request collector: finds the start bit, reads the type msb first,
// counts the length that type needs and checks the stop bit.
// assumes the request line is synchronous to the single block clock.
`timescale 1ns/1ps
module plc_req_rx (
	input wire logic clock,
	input wire logic rst,
	input wire logic req_bit,
	output logic done,
	output logic [3:0] rtype,
	output logic [12:0] payload
);
	import plc_pkg::*;

	logic busy_ff, nxt_busy;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [4:0] len_ff, nxt_len;
	logic [16:0] sh_ff, nxt_sh;
	logic done_ff, nxt_done;

	// shift in one bit per clock and close the stream at its length
	always_comb begin
		nxt_busy = busy_ff;
		nxt_cnt = cnt_ff;
		nxt_len = len_ff;
		nxt_sh = sh_ff;
		nxt_done = 1'b0;
		if (!busy_ff) begin
			if (req_bit == START_BIT) begin
				nxt_busy = 1'b1;
				nxt_cnt = 5'h01;
				nxt_len = 5'h00;
				nxt_sh = '0;
			end
		end else begin
			nxt_sh = {sh_ff[15:0], req_bit};
			nxt_cnt = cnt_ff + 5'h01;
			if (cnt_ff == 5'h04) begin
				// type complete msb first; pick the length it needs
				nxt_len = plc_len({sh_ff[2:0], req_bit});
				if (plc_len({sh_ff[2:0], req_bit}) == 5'h00) begin
					nxt_busy = 1'b0; // reserved type is dropped
				end
			end else if (cnt_ff > 5'h04 && cnt_ff == len_ff - 5'h01) begin
				nxt_busy = 1'b0;
				nxt_sh = sh_ff; // stop bit is not stored, fields stay right aligned
				nxt_done = (req_bit == STOP_BIT); // bad stop discards
			end
		end
	end

	// register the collector state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
			cnt_ff <= 5'h00;
			len_ff <= 5'h00;
			sh_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
			cnt_ff <= nxt_cnt;
			len_ff <= nxt_len;
			sh_ff <= nxt_sh;
			done_ff <= nxt_done;
		end
	end

	// sh_ff holds type then fields, stop bit excluded, right aligned
	assign done = done_ff;
	always_comb begin
		rtype = 4'h0;
		payload = 13'h0000;
		case (len_ff)
			LEN_BUS: begin
				rtype = sh_ff[8:5];
				payload = {8'h00, sh_ff[4:0]};
			end
			LEN_READ: begin
				rtype = sh_ff[7:4];
				payload = {9'h000, sh_ff[3:0]};
			end
			LEN_WRITE: begin
				rtype = sh_ff[15:12];
				payload = {1'b0, sh_ff[11:0]};
			end
			LEN_NOTIFY: begin
				rtype = sh_ff[3:0];
			end
			default: begin
				rtype = 4'h0;
			end
		endcase
	end
endmodule : plc_req_rx

/* File: hw/plc_link_end.sv */
// link end: shifts request streams out on the request line and drives the
// buses only while granted. assumes the same clock as the phy end.
`timescale 1ns/1ps
module plc_link_end (
	input wire logic clock,
	input wire logic rst,
	plc_if.link pins,
	input wire logic req_valid,
	input wire logic [3:0] req_type,
	input wire logic [12:0] req_payload,
	output logic req_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_done,
	output logic granted,
	output logic [1:0] rx_ctl,
	output logic [7:0] rx_byte
);
	import plc_pkg::*;

	logic [17:0] sh_ff, nxt_sh;
	logic [4:0] left_ff, nxt_left;
	logic req_ff, nxt_req;
	logic own_ff, nxt_own;
	logic [1:0] ctl_ff, nxt_ctl;
	logic [7:0] dat_ff, nxt_dat;
	logic [1:0] rctl_ff, nxt_rctl;
	logic [7:0] rdat_ff, nxt_rdat;

	// request shifter, msb first, one bit per clock
	always_comb begin
		nxt_sh = sh_ff;
		nxt_left = left_ff;
		nxt_req = 1'b0; // line low between streams
		if (left_ff != 5'h00) begin
			nxt_req = sh_ff[17];
			nxt_sh = {sh_ff[16:0], 1'b0};
			nxt_left = left_ff - 5'h01;
		end else if (req_valid && plc_len(req_type) != 5'h00) begin
			// start, type, fields, stop, left aligned
			case (plc_len(req_type))
				LEN_BUS: nxt_sh = {START_BIT, req_type, req_payload[4:0], STOP_BIT, 7'h00};
				LEN_READ: nxt_sh = {START_BIT, req_type, req_payload[3:0], STOP_BIT, 8'h00};
				LEN_WRITE: nxt_sh = {START_BIT, req_type, req_payload[11:0], STOP_BIT};
				default: nxt_sh = {START_BIT, req_type, STOP_BIT, 12'h000};
			endcase
			nxt_left = plc_len(req_type);
		end
	end

	// bus ownership: hold after grant, transmit, then release
	always_comb begin
		nxt_own = own_ff;
		nxt_ctl = LNK_CTL_HOLD;
		nxt_dat = 8'h00;
		nxt_rctl = pins.iface_control_pair;
		nxt_rdat = pins.iface_data_byte_bus;
		if (!own_ff) begin
			nxt_ctl = LNK_CTL_RELEASE;
			if (pins.iface_control_pair == PHY_CTL_GRANT) begin
				nxt_own = 1'b1; // drive only once granted
				nxt_ctl = LNK_CTL_HOLD; // hold from the first owned cycle
			end
		end else if (ctl_ff == LNK_CTL_RELEASE) begin
			nxt_ctl = LNK_CTL_RELEASE;
			nxt_own = 1'b0; // release code has stood one cycle, let go
		end else if (tx_done) begin
			nxt_ctl = LNK_CTL_RELEASE;
		end else if (tx_valid) begin
			nxt_ctl = LNK_CTL_TRANSMIT;
			nxt_dat = tx_byte;
		end
	end

	// registers for both groups
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sh_ff <= '0;
			left_ff <= 5'h00;
			req_ff <= 1'b0;
			own_ff <= 1'b0;
			ctl_ff <= LNK_CTL_RELEASE;
			dat_ff <= 8'h00;
			rctl_ff <= PHY_CTL_IDLE;
			rdat_ff <= 8'h00;
		end else begin
			sh_ff <= nxt_sh;
			left_ff <= nxt_left;
			req_ff <= nxt_req;
			own_ff <= nxt_own;
			ctl_ff <= nxt_ctl;
			dat_ff <= nxt_dat;
			rctl_ff <= nxt_rctl;
			rdat_ff <= nxt_rdat;
		end
	end

	assign pins.link_request_line = req_ff;
	assign pins.lnk_ctl_o = ctl_ff;
	assign pins.lnk_ctl_oe = own_ff;
	assign pins.lnk_data_o = dat_ff;
	assign pins.lnk_data_oe = own_ff;
	assign req_ready = (left_ff == 5'h00);
	assign granted = own_ff;
	assign rx_ctl = rctl_ff;
	assign rx_byte = rdat_ff;
endmodule : plc_link_end

/* File: dv/plc_props.sv */
// checker for the shared control wires between the phy end and the link end.
// assumes one clock and an asynchronous active-high reset for both ends.
`timescale 1ns/1ps
module plc_props
	import plc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] phy_ctl_o,
	input wire logic phy_ctl_oe,
	input wire logic phy_data_oe,
	input wire logic [1:0] lnk_ctl_o,
	input wire logic lnk_ctl_oe,
	input wire logic lnk_data_oe,
	input wire logic [1:0] iface_control_pair
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// never two drivers on the control pair
	chk_one_owner: assert property (!(phy_ctl_oe && lnk_ctl_oe))
		else $error("both ends drive the control pair");
	// link only takes the pair straight after a grant
	chk_link_after_grant: assert property ($rose(lnk_ctl_oe) |-> $past(iface_control_pair) == PHY_CTL_GRANT)
		else $error("link drove without a grant");
	// the link holds the pair in its first owned cycle
	chk_hold_after_grant: assert property ($rose(lnk_ctl_oe) |-> lnk_ctl_o == LNK_CTL_HOLD)
		else $error("link did not hold after grant");
	// a grant stands one cycle and hands the pair over
	chk_grant_handover: assert property (phy_ctl_oe && phy_ctl_o == PHY_CTL_GRANT |=> !phy_ctl_oe && lnk_ctl_oe)
		else $error("grant not handed over");
	// status stands a single cycle
	chk_status_single: assert property (phy_ctl_oe && phy_ctl_o == PHY_CTL_STATUS |=> !(phy_ctl_oe && phy_ctl_o == PHY_CTL_STATUS))
		else $error("status held too long");
	// link never sends the reserved code
	chk_no_reserved: assert property (lnk_ctl_oe |-> lnk_ctl_o != LNK_CTL_RESERVED)
		else $error("link sent reserved code");
	// link signals release in its last driven cycle
	chk_release_code: assert property ($fell(lnk_ctl_oe) |-> $past(lnk_ctl_o) == LNK_CTL_RELEASE)
		else $error("link left without release");
	// phy takes the pair back soon after release
	chk_phy_retakes: assert property ($fell(lnk_ctl_oe) |-> ##[0:2] phy_ctl_oe)
		else $error("phy did not retake the pair");
	// data bus is driven only by the owner of the control pair
	chk_phy_data_owner: assert property (phy_data_oe |-> phy_ctl_oe)
		else $error("phy data driven without control");
	chk_link_data_owner: assert property (lnk_data_oe |-> lnk_ctl_oe)
		else $error("link data driven without control");
endmodule : plc_props

/* File: dv/phy_link_ctl_and_request_decode_tb.sv */
// bench joining the phy end and link end through one interface.
// assumes both ends share the bench clock and reset.
`timescale 1ns/1ps
module phy_link_ctl_and_request_decode_tb;
	import plc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic pkt_arrive = 1'b0, pkt_last = 1'b0, arb_won = 1'b0, status_req = 1'b0;
	logic [7:0] pkt_byte = 8'h00, status_byte = 8'h00, tx_byte_in = 8'h00, phy_tx_byte, rx_byte;
	logic req_valid = 1'b0, tx_valid = 1'b0, tx_done = 1'b0;
	logic [3:0] req_type = 4'h0, arb_type, arb_speed;
	logic [12:0] req_payload = 13'h0000;
	logic [15:0] arb_pending, pend;
	logic arb_format, iso_phase_odd, cyc_start_due, phy_tx_valid, req_ready, granted;
	logic [1:0] rx_ctl;
	logic [127:0] reg_view, shadow;
	logic [4:0] fs [16];
	logic [31:0] lfsr = 32'h8e44;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	plc_if pins ();
	plc_phy_end i_plc_phy_end (.clock(clock), .rst(rst), .pins(pins), .pkt_arrive(pkt_arrive),
		.pkt_byte(pkt_byte), .pkt_last(pkt_last), .arb_won(arb_won), .status_req(status_req),
		.status_byte(status_byte), .arb_pending(arb_pending), .arb_type(arb_type),
		.arb_format(arb_format), .arb_speed(arb_speed), .iso_phase_odd(iso_phase_odd),
		.cyc_start_due(cyc_start_due), .tx_byte(phy_tx_byte), .tx_valid(phy_tx_valid),
		.reg_view(reg_view));
	plc_link_end i_plc_link_end (.clock(clock), .rst(rst), .pins(pins), .req_valid(req_valid),
		.req_type(req_type), .req_payload(req_payload), .req_ready(req_ready),
		.tx_valid(tx_valid), .tx_byte(tx_byte_in), .tx_done(tx_done), .granted(granted),
		.rx_ctl(rx_ctl), .rx_byte(rx_byte));
	plc_props i_plc_props (.clock(clock), .rst(rst), .phy_ctl_o(pins.phy_ctl_o),
		.phy_ctl_oe(pins.phy_ctl_oe), .phy_data_oe(pins.phy_data_oe), .lnk_ctl_o(pins.lnk_ctl_o),
		.lnk_ctl_oe(pins.lnk_ctl_oe), .lnk_data_oe(pins.lnk_data_oe),
		.iface_control_pair(pins.iface_control_pair));
	// clock and hang guard
	initial forever #12.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	// expected request stream, msb sent first, right aligned
	function automatic logic [17:0] exp_stream(input logic [3:0] t, input logic [12:0] p);
		case (t)
			RT_REG_READ: return {8'h00, START_BIT, t, p[3:0], STOP_BIT};
			RT_REG_WRITE: return {START_BIT, t, p[11:0], STOP_BIT};
			RT_PHASE_EVEN, RT_PHASE_ODD, RT_CYC_DUE: return {12'h000, START_BIT, t, STOP_BIT};
			default: return {7'h00, START_BIT, t, p[4:0], STOP_BIT};
		endcase
	endfunction : exp_stream
	function automatic int exp_len(input logic [3:0] t);
		case (t)
			RT_REG_READ: return 10;
			RT_REG_WRITE: return 18;
			RT_PHASE_EVEN, RT_PHASE_ODD, RT_CYC_DUE: return 6;
			default: return 11;
		endcase
	endfunction : exp_len
	task automatic cmp_val(input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
			fail_count++;
		end
	endtask : cmp_val
	task automatic cmp_wire(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value on wire at %0t: got %0h expected %0h", $time, got, exp);
			fail_count++;
		end
	endtask : cmp_wire
	// shift one request out and capture the request line at mid-cycle
	task automatic send(input logic [3:0] t, input logic [12:0] p);
		logic [17:0] got;
		got = 18'h0;
		for (int k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge clock);
		@(posedge clock);
		req_valid <= 1'b1;
		req_type <= t;
		req_payload <= p;
		@(posedge clock);
		req_valid <= 1'b0;
		@(negedge clock);
		for (int i = 0; i < exp_len(t); i++) begin
			@(negedge clock);
			got = {got[16:0], pins.link_request_line};
		end
		cmp_wire(got, exp_stream(t, p));
		@(negedge clock);
		cmp_wire(18'(pins.link_request_line), 18'h0);
	endtask : send
	task automatic wait_rx(input logic [1:0] code);
		@(negedge clock);
		for (int k = 0; k < 40 && rx_ctl !== code; k++) @(negedge clock);
	endtask : wait_rx
	task automatic end_sim();
		$display("errors %0d checks %0d", fail_count, checks);
		if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// main sequence
	initial begin
		logic [3:0] a;
		logic [7:0] d;
		logic [3:0] bus_t [7] = '{RT_IMMED, RT_NEXT_EVEN, RT_NEXT_ODD, RT_CURRENT,
			RT_ISO_EVEN, RT_ISO_ODD, RT_CYC_START};
		logic [3:0] rsv_t [4] = '{4'h0, 4'h5, 4'h9, 4'hf};
		logic seen;
		shadow = '0;
		pend = '0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		cmp_val(reg_view, '0);
		cmp_wire(18'(pins.iface_control_pair), 18'(PHY_CTL_IDLE));
		// notifications
		send(RT_PHASE_ODD, 13'h0000);
		repeat (4) @(negedge clock);
		cmp_val(iso_phase_odd, 1'b1);
		send(RT_PHASE_EVEN, 13'h0000);
		repeat (4) @(negedge clock);
		cmp_val(iso_phase_odd, 1'b0);
		send(RT_CYC_DUE, 13'h0000);
		repeat (4) @(negedge clock);
		cmp_val(cyc_start_due, 1'b1);
		// reserved types never reach the line
		foreach (rsv_t[j]) begin
			seen = 1'b0;
			@(posedge clock);
			req_valid <= 1'b1;
			req_type <= rsv_t[j];
			repeat (25) begin
				@(negedge clock);
				seen = seen | pins.link_request_line;
			end
			@(posedge clock);
			req_valid <= 1'b0;
			cmp_wire(18'(seen), 18'h0);
		end
		cmp_val(arb_pending, pend);
		// register writes, corner value first
		for (int j = 0; j < 5; j++) begin
			a = (j == 0) ? 4'hf : 4'(rnd());
			d = (j == 0) ? 8'hff : 8'(rnd());
			shadow[a*8 +: 8] = d;
			send(RT_REG_WRITE, {1'b0, a, d});
		end
		repeat (4) @(negedge clock);
		cmp_val(reg_view, shadow);
		// register read answered by status
		send(RT_REG_READ, {9'h000, a});
		wait_rx(PHY_CTL_STATUS);
		cmp_val(rx_ctl, PHY_CTL_STATUS);
		cmp_val(rx_byte, shadow[a*8 +: 8]);
		// autonomous status
		@(posedge clock);
		status_byte <= 8'h5a;
		status_req <= 1'b1;
		wait_rx(PHY_CTL_STATUS);
		status_req <= 1'b0;
		cmp_val(rx_byte, 8'h5a);
		// queue every bus type, last one twice to overwrite
		foreach (bus_t[j]) begin
			fs[bus_t[j]] = 5'(rnd());
			send(bus_t[j], {8'h00, fs[bus_t[j]]});
			pend[bus_t[j]] = 1'b1;
		end
		fs[RT_CYC_START] = 5'(rnd());
		send(RT_CYC_START, {8'h00, fs[RT_CYC_START]});
		repeat (4) @(negedge clock);
		cmp_val(arb_pending, pend);
		// incoming packet keeps the queue
		@(posedge clock);
		pkt_byte <= 8'hc3;
		pkt_arrive <= 1'b1;
		wait_rx(PHY_CTL_RECEIVE);
		cmp_val(rx_ctl, PHY_CTL_RECEIVE);
		cmp_val(rx_byte, 8'hc3);
		@(posedge clock);
		pkt_arrive <= 1'b0;
		pkt_last <= 1'b1;
		@(posedge clock);
		pkt_last <= 1'b0;
		wait_rx(PHY_CTL_IDLE);
		cmp_val(arb_pending, pend);
		// grant each queued type, lowest first, and send one byte
		foreach (bus_t[j]) begin
			@(posedge clock);
			arb_won <= 1'b1;
			@(posedge clock);
			arb_won <= 1'b0;
			for (int k = 0; k < 20 && granted !== 1'b1; k++) @(negedge clock);
			cmp_val(granted, 1'b1);
			cmp_wire(18'(pins.iface_control_pair), 18'(LNK_CTL_HOLD));
			cmp_val(arb_type, bus_t[j]);
			cmp_val({arb_format, arb_speed}, fs[bus_t[j]]);
			d = 8'(rnd());
			@(posedge clock);
			tx_byte_in <= d;
			tx_valid <= 1'b1;
			@(posedge clock);
			tx_valid <= 1'b0;
			for (int k = 0; k < 10 && phy_tx_valid !== 1'b1; k++) @(negedge clock);
			cmp_val(phy_tx_valid, 1'b1);
			cmp_val(phy_tx_byte, d);
			@(posedge clock);
			tx_done <= 1'b1;
			@(posedge clock);
			tx_done <= 1'b0;
			for (int k = 0; k < 20 && granted !== 1'b0; k++) @(negedge clock);
			pend[bus_t[j]] = 1'b0;
			repeat (4) @(negedge clock);
			cmp_val(arb_pending, pend);
		end
		end_sim();
	end
endmodule : phy_link_ctl_and_request_decode_tb
